// ==== dv/pad_board.sv ====
// model: board wiring and pull resistors on the pads
`timescale 1ns/1ps
`default_nettype none
module pad_board #(parameter int PINS = 4)(
  input wire logic i_clk,
  input wire logic [PINS-1:0] i_out,
  input wire logic [PINS-1:0] i_oe,
  input wire logic [PINS-1:0] i_pu,
  input wire logic [PINS-1:0] i_pd,
  input wire logic [PINS-1:0] i_ext_en,
  input wire logic [PINS-1:0] i_ext_val,
  output logic [PINS-1:0] o_pad
);
  logic [PINS-1:0] fl_q = '0;
  // undriven pad with no pull on flips each cycle, never a stale level
  always @(posedge i_clk) fl_q <= ~fl_q;
  always_comb
    for (int p = 0; p < PINS; p++)
      o_pad[p] = i_oe[p] ? i_out[p] : i_ext_en[p] ? i_ext_val[p] : i_pu[p] | (~i_pd[p] & fl_q[p]);
endmodule
`default_nettype wire

// ==== dv/pin_io_chk.sv ====
// checker: pin control port assertions
`timescale 1ns/1ps
`default_nettype none
module pin_io_chk #(parameter int PINS = 4)(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_core_overvoltage_detect,
  input wire logic [PINS-1:0] o_pad_out,
  input wire logic [PINS-1:0] o_pad_oe,
  input wire logic [PINS-1:0] o_pullup_on,
  input wire logic [PINS-1:0] o_pulldown_on,
  input wire logic [PINS-1:0] o_digital_in_enable,
  input wire logic [PINS-1:0] o_pin_level_rdata,
  input wire logic [PINS-1:0] o_analog_select_rdata,
  input wire logic o_tristate_active
);
  // ----------
  // properties
  // ----------
  wire ovd = i_core_overvoltage_detect;
  wire ts = o_tristate_active;
  wire [PINS-1:0] ana = o_analog_select_rdata;
  wire [PINS-1:0] dig = o_pin_level_rdata | o_digital_in_enable;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  chk_ts_oe_off: assert property (ts |-> o_pad_oe == '0)
    else $error("pad driven in tristate");
  chk_ts_pulls: assert property (ts |-> !(o_pullup_on | o_pulldown_on))
    else $error("pull on in tristate");
  chk_ts_out_low: assert property (ts |-> o_pad_out == '0)
    else $error("pad data not parked in tristate");
  chk_ov_enter: assert property (ovd[*4] |=> ts)
    else $error("tristate late");
  chk_ov_hold: assert property (ovd[*3] ##0 ts |=> ts)
    else $error("tristate dropped early");
  chk_ov_leave: assert property ((!ovd)[*4] |=> !ts)
    else $error("tristate stuck");
  chk_ov_sync: assert property ((!ovd)[*3] ##1 ovd |=> (!ts)[*2])
    else $error("detect not synchronised");
  chk_reset_analog: assert property ($rose(i_arst_n) |=> ana == '1)
    else $error("pin not analog after reset");
  chk_analog_mask: assert property ($stable(ana) |-> !(dig & ana))
    else $error("analog pin reads digital");
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// testbench: pin control block against the board model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pin_io_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ov = 1'b0;
  logic [7:0] pen = 8'h00;
  logic [7:0] pout = 8'h00;
  logic [7:0] poe = 8'h00;
  logic [3:0] wd [5] = '{default: 4'h0};
  logic [4:0] we = 5'h00;
  logic [3:0] ext_en = 4'hf;
  logic [3:0] ext_val = 4'hf;
  logic [3:0] pad, out, oe, pu, pd, din, lvl, lat, ana, dir;
  logic ts;
  int bad_count = 0;
  int checks = 0;
  pin_io_control #(.PINS(4), .FUNCS(2)) pin_io_control_i (
    .i_ref_clk(clk), .i_arst_n(rst_n), .i_core_overvoltage_detect(ov),
    .i_analog_select_wdata(wd[0]), .i_analog_select_we(we[0]),
    .i_direction_wdata(wd[1]), .i_direction_we(we[1]),
    .i_output_latch_wdata(wd[2]), .i_output_latch_we(we[2]),
    .i_pullup_enable_wdata(wd[3]), .i_pullup_enable_we(we[3]),
    .i_pulldown_enable_wdata(wd[4]), .i_pulldown_enable_we(we[4]),
    .i_periph_enable(pen), .i_periph_out(pout), .i_periph_oe(poe), .i_pad_in(pad),
    .o_pad_out(out), .o_pad_oe(oe), .o_pullup_on(pu), .o_pulldown_on(pd),
    .o_digital_in_enable(din), .o_pin_level_rdata(lvl), .o_output_latch_rdata(lat),
    .o_analog_select_rdata(ana), .o_direction_rdata(dir), .o_tristate_active(ts));
  pad_board #(.PINS(4)) pad_board_i (.i_clk(clk), .i_out(out), .i_oe(oe), .i_pu(pu),
    .i_pd(pd), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));
  task automatic wr(input int k, input logic [3:0] d);
    @(negedge clk);
    wd[k] = d;
    we[k] = 1'b1;
    @(negedge clk);
    we[k] = 1'b0;
    // one edge to the outputs after the write, one more for the pad readback, one spare
    repeat (3) @(negedge clk);
  endtask
  task automatic cmp(input string n, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wait_ts(input logic v);
    for (int n = 0; n < 10 && ts !== v; n++)
      @(negedge clk);
    cmp("tristate", {3'h0, v}, {3'h0, ts});
    if (ts !== v)
      test_done;
  endtask
  initial forever #4 clk = ~clk;
  initial
  begin
    repeat (16) @(negedge clk);
    cmp("analog", {4{ANALOG_RESET_BIT}}, ana);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    cmp("din", 4'h0, din);
    cmp("level", 4'h0, lvl);
    wr(0, 4'h3);
    cmp("level", 4'hc, lvl);
    cmp("din", 4'hc, din);
    ext_en = 4'h0;
    wr(2, 4'ha);
    wr(1, {4{DIR_OUTPUT_BIT}});
    cmp("oe", 4'hf, oe);
    cmp("direction", {4{DIR_OUTPUT_BIT}}, dir);
    cmp("out", 4'ha, out);
    cmp("latch", 4'h8, lat);
    pen = 8'h0b;
    pout = 8'h09;
    poe = 8'h03;
    repeat (2) @(negedge clk);
    cmp("out", 4'hb, out);
    cmp("oe", 4'hd, oe);
    pen = 8'h00;
    wr(1, {4{DIR_INPUT_BIT}});
    wr(3, 4'h5);
    wr(4, 4'ha);
    cmp("pulldown", 4'ha, pd);
    cmp("pullup", 4'h5, pu);
    cmp("level", 4'h4, lvl);
    wr(1, 4'h0);
    ov = 1'b1;
    @(negedge clk);
    ov = 1'b0;
    repeat (4) @(negedge clk);
    ov = 1'b1;
    wait_ts(1'b1);
    cmp("pullup", 4'h0, pu);
    repeat (20) @(negedge clk);
    cmp("oe", 4'h0, oe);
    cmp("out", 4'h0, out);
    ov = 1'b0;
    wait_ts(1'b0);
    cmp("oe", 4'hf, oe);
    rst_n = 1'b0;
    @(negedge clk);
    cmp("analog", 4'hf, ana);
    test_done;
  end
endmodule
bind pin_io_control pin_io_chk #(.PINS(PINS)) pin_io_chk_i (.i_ref_clk, .i_arst_n,
  .i_core_overvoltage_detect, .o_pad_out, .o_pad_oe, .o_pullup_on, .o_pulldown_on,
  .o_digital_in_enable, .o_pin_level_rdata, .o_analog_select_rdata, .o_tristate_active);
`default_nettype wire

// ==== rtl/pin_func_arbiter.sv ====
// module: fixed priority choice among functions sharing one pin
`timescale 1ns/1ps
`default_nettype none
module pin_func_arbiter
  import pin_io_pkg::*;
#(
  parameter int FUNCS = FUNC_COUNT_DEFAULT
)(
  pin_route_if.arbiter route
);
  // refused at elaboration: an arbiter with no functions has nothing to pick
  generate
    if (FUNCS < 1)
    begin : g_bad_size
      $error("pin_func_arbiter: FUNCS must be at least 1");
    end
  endgenerate
  // ----------------------------------------
  // priority pick
  // ----------------------------------------
  // index 0 is the rightmost (lowest), highest priority function
  always_comb
  begin
    route.win_out = 1'b0;
    route.win_oe = 1'b0;
    route.win_func = 1'b0;
    for (int k = FUNCS - 1; k >= 0; k--)
    begin
      if (route.fn_enable[k])
      begin
        route.win_out = route.fn_out[k];
        route.win_oe = route.fn_oe[k];
        route.win_func = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pin_io_control.sv ====
// module: per-pin analog/digital, direction, pulls and overvoltage tri-state
// Function
// - every analog-capable pin resets to analog
// - analog pins read zero on level and latch
// - writing zero selects digital, re-enables input
// - output driver allowed while analog is selected
// - lowest-indexed (rightmost) enabled function owns the pin
// - independent weak pull-up and pull-down per pin
// - core overvoltage forces all pins high impedance
// - tri-state held while overvoltage indication stays
`timescale 1ns/1ps
`default_nettype none
module pin_io_control
  import pin_io_pkg::*;
#(
  parameter int PINS = PIN_COUNT_DEFAULT,
  parameter int FUNCS = FUNC_COUNT_DEFAULT,
  parameter logic [PINS-1:0] ANALOG_CAPABLE = '1
)(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [PINS-1:0] i_analog_select_wdata,
  input wire logic i_analog_select_we,
  input wire logic [PINS-1:0] i_direction_wdata,
  input wire logic i_direction_we,
  input wire logic [PINS-1:0] i_output_latch_wdata,
  input wire logic i_output_latch_we,
  input wire logic [PINS-1:0] i_pullup_enable_wdata,
  input wire logic i_pullup_enable_we,
  input wire logic [PINS-1:0] i_pulldown_enable_wdata,
  input wire logic i_pulldown_enable_we,
  input wire logic [PINS*FUNCS-1:0] i_periph_enable,
  input wire logic [PINS*FUNCS-1:0] i_periph_out,
  input wire logic [PINS*FUNCS-1:0] i_periph_oe,
  input wire logic i_core_overvoltage_detect,
  input wire logic [PINS-1:0] i_pad_in,
  output logic [PINS-1:0] o_pad_out,
  output logic [PINS-1:0] o_pad_oe,
  output logic [PINS-1:0] o_pullup_on,
  output logic [PINS-1:0] o_pulldown_on,
  output logic [PINS-1:0] o_digital_in_enable,
  output logic [PINS-1:0] o_pin_level_rdata,
  output logic [PINS-1:0] o_output_latch_rdata,
  output logic [PINS-1:0] o_analog_select_rdata,
  output logic [PINS-1:0] o_direction_rdata,
  output logic o_tristate_active
);
  generate
    if (PINS < 1 || FUNCS < 1)
    begin : g_bad_size
      $error("pin_io_control: PINS and FUNCS must be at least 1");
    end
  endgenerate
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [PINS-1:0] analog_select_q;
  logic [PINS-1:0] direction_q;
  logic [PINS-1:0] output_latch_q;
  logic [PINS-1:0] pullup_enable_q;
  logic [PINS-1:0] pulldown_enable_q;
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      analog_select_q <= {PINS{ANALOG_RESET_BIT}};
    else if (i_analog_select_we)
      analog_select_q <= i_analog_select_wdata;
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      direction_q <= {PINS{DIR_INPUT_BIT}};
    else if (i_direction_we)
      direction_q <= i_direction_wdata;
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      output_latch_q <= {PINS{LATCH_RESET_BIT}};
    else if (i_output_latch_we)
      output_latch_q <= i_output_latch_wdata;
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pullup_enable_q <= {PINS{PULL_RESET_BIT}};
      pulldown_enable_q <= {PINS{PULL_RESET_BIT}};
    end
    else
    begin
      if (i_pullup_enable_we)
        pullup_enable_q <= i_pullup_enable_wdata;
      if (i_pulldown_enable_we)
        pulldown_enable_q <= i_pulldown_enable_wdata;
    end
  end
  // pins without an analog function can never be analog
  logic [PINS-1:0] analog_eff;
  assign analog_eff = analog_select_q & ANALOG_CAPABLE;
  // ----------------------------------------
  // overvoltage synchroniser
  // ----------------------------------------
  // detector is asynchronous to the core clock; first stage read only by second
  logic ov_meta_q;
  logic ov_sync_q;
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ov_meta_q <= 1'b0;
      ov_sync_q <= 1'b0;
    end
    else
    begin
      ov_meta_q <= i_core_overvoltage_detect;
      ov_sync_q <= ov_meta_q;
    end
  end
  port_mode_type mode;
  assign mode = ov_sync_q ? PORT_TRISTATE : PORT_NORMAL;
  // ----------------------------------------
  // per-pin routing
  // ----------------------------------------
  // nets, so each pin slice below has exactly one driver
  wire logic [PINS-1:0] pin_out_d;
  wire logic [PINS-1:0] pin_oe_d;
  genvar p;
  generate
    for (p = 0; p < PINS; p++)
    begin : g_pin
      pin_route_if #(.FUNCS(FUNCS)) route ();
      assign route.fn_enable = i_periph_enable[p*FUNCS +: FUNCS];
      assign route.fn_out = i_periph_out[p*FUNCS +: FUNCS];
      assign route.fn_oe = i_periph_oe[p*FUNCS +: FUNCS];
      pin_func_arbiter #(.FUNCS(FUNCS)) u_arb (
        .route(route.arbiter)
      );
      logic sel_out;
      logic sel_oe;
      always_comb
      begin
        if (mode == PORT_TRISTATE)
        begin
          sel_out = 1'b0;
          sel_oe = 1'b0;
        end
        else if (route.win_func)
        begin
          sel_out = route.win_out;
          sel_oe = route.win_oe;
        end
        else
        begin
          // analog select does not block the driver
          sel_out = output_latch_q[p];
          sel_oe = (direction_q[p] == DIR_OUTPUT_BIT);
        end
      end
      assign pin_out_d[p] = sel_out;
      assign pin_oe_d[p] = sel_oe;
    end
  endgenerate
  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pad_out <= '0;
      o_pad_oe <= '0;
      o_tristate_active <= 1'b0;
    end
    else
    begin
      o_pad_out <= pin_out_d;
      o_pad_oe <= pin_oe_d;
      o_tristate_active <= ov_sync_q;
    end
  end
  // pulls are switched off with the rest of the pad in tri-state
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pullup_on <= '0;
      o_pulldown_on <= '0;
    end
    else
    begin
      o_pullup_on <= ov_sync_q ? '0 : pullup_enable_q;
      o_pulldown_on <= ov_sync_q ? '0 : pulldown_enable_q;
    end
  end
  // pad input is treated as synchronous here
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_digital_in_enable <= '0;
      o_pin_level_rdata <= '0;
      o_output_latch_rdata <= '0;
    end
    else
    begin
      o_digital_in_enable <= ~analog_eff;
      o_pin_level_rdata <= i_pad_in & ~analog_eff;
      o_output_latch_rdata <= output_latch_q & ~analog_eff;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_analog_select_rdata <= {PINS{ANALOG_RESET_BIT}};
      o_direction_rdata <= {PINS{DIR_INPUT_BIT}};
    end
    else
    begin
      o_analog_select_rdata <= analog_select_q;
      o_direction_rdata <= direction_q;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pin_io_pkg.sv ====
// package: constants for the pin i/o control block
package pin_io_pkg;
  localparam int PIN_COUNT_DEFAULT = 16;
  localparam int FUNC_COUNT_DEFAULT = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic ANALOG_RESET_BIT = 1'b1;
  localparam logic DIR_INPUT_BIT = 1'b1;
  localparam logic DIR_OUTPUT_BIT = 1'b0;
  localparam logic LATCH_RESET_BIT = 1'b0;
  localparam logic PULL_RESET_BIT = 1'b0;
  typedef enum logic [0:0] {
    PORT_NORMAL = 1'b0,
    PORT_TRISTATE = 1'b1
  } port_mode_type;
endpackage

// ==== rtl/pin_route_if.sv ====
// interface: carries per-pin function requests into the arbiter
`timescale 1ns/1ps
`default_nettype none
interface pin_route_if #(
  parameter int FUNCS = 4
);
  logic [FUNCS-1:0] fn_enable;
  logic [FUNCS-1:0] fn_out;
  logic [FUNCS-1:0] fn_oe;
  logic win_out;
  logic win_oe;
  logic win_func;
  modport requester (output fn_enable, output fn_out, output fn_oe,
    input win_out, input win_oe, input win_func);
  modport arbiter (input fn_enable, input fn_out, input fn_oe,
    output win_out, output win_oe, output win_func);
endinterface
`default_nettype wire
